// File: hw/shutter_pkg.sv
package shutter_pkg;
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned US_PER_S     = 1_000_000;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / US_PER_S;
  localparam int unsigned US_PER_MS    = 1000;
  localparam int unsigned NUM_LINES    = 4;
  localparam int unsigned PERIOD_MS_W  = 16;
  localparam int unsigned TIME_US_W    = 26;
  // Idle cycle of one microsecond so a first correction lands at once
  localparam logic [PERIOD_MS_W-1:0] PERIOD_RESET = 16'h0000;

  typedef struct packed {
    logic [TIME_US_W-1:0] on_us;
    logic [TIME_US_W-1:0] off_us;
    logic                 right_eye;
    logic                 enable;
  } line_cfg_t;

  typedef struct packed {
    logic [PERIOD_MS_W-1:0]         period_ms;
    logic [TIME_US_W-1:0]           phase_adj_us;
    line_cfg_t [NUM_LINES-1:0]      line;
  } timing_msg_t;
endpackage

// File: hw/stereo_shutter_pulse_timer.sv
`timescale 1ns/1ps
module stereo_shutter_pulse_timer #(
  parameter int unsigned LINES = shutter_pkg::NUM_LINES
) (
  input  wire logic                                clk_i,
  input  wire logic                                arst_n_i,
  input  wire logic                                msg_valid_i,
  input  wire shutter_pkg::timing_msg_t            msg_i,
  output logic [LINES-1:0]                         shutter_o,
  output logic [LINES-1:0]                         eye_right_o,
  output logic                                     cycle_start_o,
  output logic                                     msg_pending_o
);
  localparam int unsigned TW = shutter_pkg::TIME_US_W;
  localparam int unsigned TC = shutter_pkg::TICK_CYCLES;

  // Refuse sizes the logic cannot serve
  if (LINES < 1 || LINES > shutter_pkg::NUM_LINES) begin : g_bad_lines
    $error("LINES must be 1 to 4");
  end

  // Prescaler is only eight bits wide
  if (TC < 1 || TC > 256) begin : g_bad_tick
    $error("TICK_CYCLES must be 1 to 256");
  end

  // Longest period must fit the microsecond counter
  if (TW < 26) begin : g_bad_time
    $error("TIME_US_W too narrow for 65535 ms");
  end

  // One-microsecond enable from the system clock
  logic [7:0] pre_q;
  logic [7:0] pre_d;
  logic       tick;

  assign tick = (pre_q == 8'(TC - 1));

  always_comb begin
    if (tick) begin
      pre_d = 8'h00;
    end else begin
      pre_d = pre_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= pre_d;
    end
  end

  // Message path
  shutter_pkg::timing_msg_t act_q;
  shutter_pkg::timing_msg_t act_d;
  shutter_pkg::timing_msg_t pend_q;
  logic                     pend_v_q;
  logic                     pend_v_d;
  logic                     apply;

  // Cycle path
  logic [TW-1:0]            cyc_q;
  logic [TW-1:0]            cyc_d;
  logic [TW-1:0]            period_us;
  logic                     wrap;

  // Period in microseconds; 65535 ms still fits in 26 bits
  assign period_us = TW'(act_q.period_ms) *
                     TW'(shutter_pkg::US_PER_MS);

  // Period zero wraps on every tick
  assign wrap  = tick && (cyc_q + TW'(1) >= period_us);
  assign apply = wrap && pend_v_q;

  // Shared cycle counter for every line
  // Limitation: a phase beyond the new period wraps on the next tick
  always_comb begin
    if (apply) begin
      cyc_d = pend_q.phase_adj_us;
    end else if (wrap) begin
      cyc_d = '0;
    end else if (tick) begin
      cyc_d = cyc_q + TW'(1);
    end else begin
      cyc_d = cyc_q;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cyc_q <= '0;
    end else begin
      cyc_q <= cyc_d;
    end
  end

  // A message in the wrap cycle stays pending for the next boundary
  assign pend_v_d = msg_valid_i || (pend_v_q && !wrap);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_v_q <= 1'b0;
    end else begin
      pend_v_q <= pend_v_d;
    end
  end

  // Newest message replaces an older one not yet applied
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_q <= '0;
    end else if (msg_valid_i) begin
      pend_q <= msg_i;
    end
  end

  // Whole set switches at once, so no pulse is cut or doubled
  always_comb begin
    if (apply) begin
      act_d = pend_q;
    end else begin
      act_d = act_q;
    end
  end

  // Shutter and eye outputs idle low until the first message is applied
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      act_q           <= '0;
      act_q.period_ms <= shutter_pkg::PERIOD_RESET;
    end else begin
      act_q <= act_d;
    end
  end

  // One comparator cell per line, all fed by the same counter
  for (genvar i = 0; i < LINES; i++) begin : g_line
    shutter_line_cell #(
      .TW(TW)
    ) shutter_line_cell_i (
      .clk_i      (clk_i),
      .arst_n_i   (arst_n_i),
      .cyc_i      (cyc_q),
      .on_us_i    (act_q.line[i].on_us),
      .off_us_i   (act_q.line[i].off_us),
      .enable_i   (act_q.line[i].enable),
      .eye_right_i(act_d.line[i].right_eye),
      .shutter_o  (shutter_o[i]),
      .eye_right_o(eye_right_o[i])
    );
  end

  // Status flags move on the same edge as the boundary
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cycle_start_o <= 1'b0;
    end else begin
      cycle_start_o <= wrap;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      msg_pending_o <= 1'b0;
    end else begin
      msg_pending_o <= pend_v_d;
    end
  end
endmodule

module shutter_line_cell #(
  parameter int unsigned TW = shutter_pkg::TIME_US_W
) (
  input  wire logic          clk_i,
  input  wire logic          arst_n_i,
  input  wire logic [TW-1:0] cyc_i,
  input  wire logic [TW-1:0] on_us_i,
  input  wire logic [TW-1:0] off_us_i,
  input  wire logic          enable_i,
  input  wire logic          eye_right_i,
  output logic               shutter_o,
  output logic               eye_right_o
);

  if (TW < 1) begin : g_bad_width
    $error("TW must be at least 1");
  end

  logic on_d;

  // Line is high from on_us up to off_us within each cycle
  // Equal or reversed times give no pulse at all
  always_comb begin
    on_d = 1'b0;
    if (enable_i) begin
      if ((cyc_i >= on_us_i) && (cyc_i < off_us_i)) begin
        on_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shutter_o <= 1'b0;
    end else begin
      shutter_o <= on_d;
    end
  end

  // Eye select follows the set that is live in this cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      eye_right_o <= 1'b0;
    end else begin
      eye_right_o <= eye_right_i;
    end
  end
endmodule

// File: sim/shutter_ctrl_model.sv
`timescale 1ns/1ps
module shutter_ctrl_model (
  input  wire logic                     clk_i,
  input  wire logic                     send_i,
  input  wire shutter_pkg::timing_msg_t cfg_i,
  output logic                          msg_valid_o,
  output shutter_pkg::timing_msg_t      msg_o
);
  initial {msg_valid_o, msg_o} = '0;
  // Idle word toggles so stale data never looks valid
  always @(posedge clk_i) begin
    msg_valid_o <= send_i;
    msg_o       <= send_i ? cfg_i : ~msg_o;
  end
endmodule

// File: sim/shutter_sva.sv
`timescale 1ns/1ps
module shutter_sva #(parameter int unsigned LINES = 4) (
  input wire logic             clk_i,
  input wire logic             arst_n_i,
  input wire logic             msg_valid_i,
  input wire logic [LINES-1:0] shutter_o,
  input wire logic [LINES-1:0] eye_right_o,
  input wire logic             cycle_start_o,
  input wire logic             msg_pending_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_pend_set: assert property (msg_valid_i |=> msg_pending_o)
    else $error("pending flag missing");
  a_pend_cause: assert property ($rose(msg_pending_o) |-> $past(msg_valid_i))
    else $error("pending without message");
  a_pend_clear: assert property ($fell(msg_pending_o) |-> cycle_start_o)
    else $error("pending cleared off boundary");
  a_start_keep: assert property (cycle_start_o && $past(msg_pending_o)
    |-> !msg_pending_o || $past(msg_valid_i))
    else $error("pending left after wrap");
  a_eye_bound: assert property ($changed(eye_right_o) |-> cycle_start_o)
    else $error("eye select moved mid cycle");
  a_shut_tick: assert property ($changed(shutter_o) |=> $stable(shutter_o)[*8])
    else $error("shutter edge off tick");
  a_start_gap: assert property (cycle_start_o |=> !cycle_start_o[*8])
    else $error("cycle start too close");
  c_start: cover property (cycle_start_o);
  c_pend: cover property (msg_pending_o && msg_valid_i);
  c_shut: cover property (shutter_o != '0);
endmodule

// File: sim/stereo_shutter_pulse_timer_tb_top.sv
`timescale 1ns/1ps
`define CHK(a,b) checked++; if ((a)!==(b)) begin fail_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end
module stereo_shutter_pulse_timer_tb_top;
  logic clk_i = 0, arst_n_i = 0, send = 0, vld, start, pend;
  logic [3:0] shut, eye;
  shutter_pkg::timing_msg_t cfg = '0, msg;
  int fail_count = 0, checked = 0, cyc = 0, n;
  always #4 clk_i = ~clk_i;
  shutter_ctrl_model shutter_ctrl_model_i (.clk_i, .send_i(send),
    .cfg_i(cfg), .msg_valid_o(vld), .msg_o(msg));
  stereo_shutter_pulse_timer stereo_shutter_pulse_timer_i (.clk_i, .arst_n_i,
    .msg_valid_i(vld), .msg_i(msg), .shutter_o(shut), .eye_right_o(eye),
    .cycle_start_o(start), .msg_pending_o(pend));
  task complete_run;
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_i) if (++cyc == 20000) begin
    fail_count++;
    complete_run;
  end
  task wait_start(output int k);
    k = 1;
    @(negedge clk_i);
    while (start !== 1'b1 && k < 10000) begin @(negedge clk_i); k++; end
  endtask
  // Two words back to back: only the later one may take effect
  task t_apply;
    cfg.line[0] = '{26'h0, 26'h1, 1'h0, 1'h1};
    cfg.line[2] = '{26'h0, 26'h5, 1'h1, 1'h1};
    @(negedge clk_i) send = 1;
    @(negedge clk_i) cfg.line[1] = '{26'h0, 26'h1, 1'h1, 1'h1};
    @(negedge clk_i) send = 0;
    @(negedge clk_i) `CHK(pend, 1'h1)
    `CHK(shut, 4'h0)
    wait_start(n);
    `CHK(eye, 4'h6)
    `CHK(pend, 1'h0)
    @(negedge clk_i) `CHK(shut, 4'h7)
    wait_start(n);
    // One negedge went to the shutter check
    `CHK(n, shutter_pkg::TICK_CYCLES - 1)
  endtask
  initial begin
    repeat (4) @(negedge clk_i);
    `CHK({shut, eye, start, pend}, 10'h0)
    arst_n_i = 1;
    t_apply;
    complete_run;
  end
endmodule
bind stereo_shutter_pulse_timer shutter_sva #(.LINES(LINES)) shutter_sva_i (
  .clk_i, .arst_n_i, .msg_valid_i, .shutter_o, .eye_right_o, .cycle_start_o,
  .msg_pending_o);
